// ---- css_consts.svh ----
`ifndef CSS_CONSTS_SVH
`define CSS_CONSTS_SVH

// configuration indices (function 0 byte registers, function 1 dword register)
`define CSS_F1_BASE_IDX      8'h10
`define CSS_SUSPEND_CFG_IDX  8'h96
`define CSS_SUSPEND_CMD_IDX  8'hae
`define CSS_CLK_STOP_IDX     8'hbc

// reset values and writable masks
`define CSS_BASE_RESET       32'h00000000
`define CSS_SUSPEND_CFG_RESET 8'h00
`define CSS_CLK_STOP_RESET   8'h00
`define CSS_BASE_WR_MASK     32'hffffff00
`define CSS_SUSPEND_CFG_MASK 8'h1f
`define CSS_CLK_STOP_MASK    8'hf1

// suspend configuration fields
`define CSS_CFG_MOD_EN       0
`define CSS_CFG_SMI_SPEEDUP  1
`define CSS_CFG_3V_MODE      2
`define CSS_CFG_ISA_GATE     3
`define CSS_CFG_PWR_SAVE_DIS 4

// clock stop control fields
`define CSS_CSC_FULL_SUSPEND 0
`define CSS_CSC_DELAY_LSB    4
`define CSS_CSC_DELAY_MSB    7

// status block window
`define CSS_WIN_SPEEDUP_DIS  8'h08
`define CSS_WIN_ACPI_TMR     8'h1c
`define CSS_WIN_ACPI_TOP     4'hf
`define CSS_IO_ACPI_TMR      16'h121c

// timing
`define CSS_CLK_MHZ          100
`define CSS_RESYNC_UNIT_US   1000
`define CSS_MOD_INTERVAL_US  32
`define CSS_STRAP_SETTLE     2'h3

`endif

// ---- css_pkg.sv ----
`default_nettype none
package css_pkg;

  typedef enum logic [4:0] {
    CSS_IDLE     = 5'b00001,
    CSS_REQ      = 5'b00010,
    CSS_HALTED   = 5'b00100,
    CSS_CLK_STOP = 5'b01000,
    CSS_RESYNC   = 5'b10000
  } css_state_t;

endpackage : css_pkg

`default_nettype wire

// ---- css_modulator.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "css_consts.svh"

module css_modulator #(
  parameter int INTERVAL_CYCLES = `CSS_MOD_INTERVAL_US * `CSS_CLK_MHZ
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       inhibit,
  input  wire logic [7:0] off_count,
  input  wire logic [7:0] on_count,
  output logic            assert_req
);

  localparam int IW = $clog2(INTERVAL_CYCLES + 1);

  logic [IW-1:0] tick_cnt;
  logic [7:0]    phase_cnt;
  logic          tick;

  assign tick = (tick_cnt == IW'(INTERVAL_CYCLES - 1));

  // 32 us timebase, restarted whenever modulation is held off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
    end else if (!enable || inhibit || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + IW'(1);
    end
  end

  // off count intervals asserted, then on count intervals released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      assert_req <= 1'b0;
      phase_cnt  <= 8'h00;
    end else if (!enable || inhibit || off_count == 8'h00) begin
      assert_req <= 1'b0;
      phase_cnt  <= 8'h00;
    end else if (tick) begin
      if (assert_req && phase_cnt + 8'h01 >= off_count) begin
        assert_req <= (on_count == 8'h00);
        phase_cnt  <= 8'h00;
      end else if (!assert_req && phase_cnt + 8'h01 >= on_count) begin
        assert_req <= 1'b1;
        phase_cnt  <= 8'h00;
      end else begin
        phase_cnt <= phase_cnt + 8'h01;
      end
    end else if (!assert_req && phase_cnt == 8'h00 && on_count == 8'h00) begin
      assert_req <= 1'b1;
    end
  end

endmodule : css_modulator

`default_nettype wire

// ---- css_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "css_consts.svh"

module css_sequencer #(
  parameter int MS_CYCLES       = `CSS_RESYNC_UNIT_US * `CSS_CLK_MHZ,
  parameter int INTERVAL_CYCLES = `CSS_MOD_INTERVAL_US * `CSS_CLK_MHZ
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic        CFG_FUNC,
  input  wire logic [7:0]  CFG_INDEX,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  input  wire logic        MEM_RD,
  input  wire logic [31:0] MEM_ADDR,
  output logic             MEM_HIT,
  output logic      [31:0] MEM_RDATA,
  input  wire logic        IO_RD,
  input  wire logic [15:0] IO_ADDR,
  output logic             IO_HIT,
  output logic      [31:0] IO_RDATA,
  input  wire logic [31:0] ACPI_TIMER_COUNT,
  input  wire logic [7:0]  MOD_OFF_COUNT,
  input  wire logic [7:0]  MOD_ON_COUNT,
  input  wire logic        SPEEDUP_ACTIVE,
  output logic             SPEEDUP_LOAD,
  output logic             CPU_SUSPEND_REQUEST_N,
  input  wire logic        CPU_SUSPEND_ACK_N,
  input  wire logic        CPU_INTERRUPT_REQUEST,
  input  wire logic        IRQ_UNMASKED,
  input  wire logic        EXT_SMI_N,
  output logic             SYSTEM_MGMT_INTERRUPT_N,
  input  wire logic        CLK_32K,
  output logic             DEVICE_TIMER_TICK,
  input  wire logic        CLOCK_STOP_INDICATOR_IN,
  output logic             CLOCK_STOP_INDICATOR_OUT,
  output logic             CLOCK_STOP_INDICATOR_OE,
  output logic             INTERNAL_CLK_GATE,
  output logic             ISA_CLK_GATE,
  output logic             CPU_POWER_OFF_OK
);

  localparam int MW = $clog2(MS_CYCLES + 1);

  // pin inputs: ack_n, cpu_interrupt_request, irq, smi_n, 32k, clock stop pin
  logic [5:0] sync1;
  logic [5:0] sync2;
  logic       ack_s;
  logic       cpu_interrupt_request_s;
  logic       irq_s;
  logic       smi_s;
  logic       k32_s;
  logic       csi_s;
  logic       smi_d;
  logic       k32_d;
  logic       smi_evt;

  css_pkg::css_state_t state;
  css_pkg::css_state_t next_state;

  logic [31:0]   base;
  logic [7:0]    suspend_cfg;
  logic [7:0]    clk_stop_ctl;
  logic          cmd_wr;
  logic          smi_halt;
  logic          mod_assert;
  logic          mod_inhibit;
  logic          win_rd;
  logic [7:0]    win_off;
  logic          break_cpu;
  logic          break_stop;
  logic          full_suspend;
  logic          resync_done;
  logic [3:0]    ms_left;
  logic [MW-1:0] ms_cnt;
  logic [1:0]    strap_cnt;
  logic          strap_done;
  logic          csi_inactive;
  logic          csi_active_now;

  function automatic logic win_is_timer(input logic [7:0] off);
    win_is_timer = (off[7:4] == `CSS_WIN_ACPI_TOP) ||
                   ({off[7:2], 2'b00} == `CSS_WIN_ACPI_TMR);
  endfunction : win_is_timer

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync1 <= 6'h3f;
      sync2 <= 6'h3f;
    end else begin
      sync1 <= {CLOCK_STOP_INDICATOR_IN, CLK_32K, EXT_SMI_N, IRQ_UNMASKED,
                CPU_INTERRUPT_REQUEST, CPU_SUSPEND_ACK_N};
      sync2 <= sync1;
    end
  end

  assign ack_s  = ~sync2[0];
  assign cpu_interrupt_request_s = sync2[1];
  assign irq_s  = sync2[2];
  assign smi_s  = ~sync2[3];
  assign k32_s  = sync2[4];
  assign csi_s  = sync2[5];

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      smi_d <= 1'b0;
      k32_d <= 1'b1;
    end else begin
      smi_d <= smi_s;
      k32_d <= k32_s;
    end
  end

  assign smi_evt = smi_s && !smi_d;

  // device timers step on the 32k edge so they keep time across clock stop
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DEVICE_TIMER_TICK <= 1'b0;
    end else begin
      DEVICE_TIMER_TICK <= k32_s && !k32_d;
    end
  end

  // configuration writes
  assign cmd_wr = CFG_WR && !CFG_FUNC && CFG_INDEX == `CSS_SUSPEND_CMD_IDX;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      base         <= `CSS_BASE_RESET;
      suspend_cfg  <= `CSS_SUSPEND_CFG_RESET;
      clk_stop_ctl <= `CSS_CLK_STOP_RESET;
    end else if (CFG_WR) begin
      if (CFG_FUNC && CFG_INDEX == `CSS_F1_BASE_IDX) begin
        base <= CFG_WDATA & `CSS_BASE_WR_MASK;
      end
      if (!CFG_FUNC && CFG_INDEX == `CSS_SUSPEND_CFG_IDX) begin
        suspend_cfg <= CFG_WDATA[7:0] & `CSS_SUSPEND_CFG_MASK;
      end
      if (!CFG_FUNC && CFG_INDEX == `CSS_CLK_STOP_IDX) begin
        clk_stop_ctl <= CFG_WDATA[7:0] & `CSS_CLK_STOP_MASK;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CFG_RDATA <= 32'h00000000;
    end else if (CFG_RD) begin
      if (CFG_FUNC && CFG_INDEX == `CSS_F1_BASE_IDX) begin
        CFG_RDATA <= base;
      end else if (!CFG_FUNC && CFG_INDEX == `CSS_SUSPEND_CFG_IDX) begin
        CFG_RDATA <= {24'h000000, suspend_cfg};
      end else if (!CFG_FUNC && CFG_INDEX == `CSS_CLK_STOP_IDX) begin
        CFG_RDATA <= {24'h000000, clk_stop_ctl};
      end else begin
        CFG_RDATA <= 32'h00000000;
      end
    end
  end

  // status block window, 256-byte aligned at base
  assign win_rd  = MEM_RD && MEM_ADDR[31:8] == base[31:8];
  assign win_off = MEM_ADDR[7:0];

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      MEM_HIT   <= 1'b0;
      MEM_RDATA <= 32'h00000000;
    end else begin
      MEM_HIT   <= win_rd;
      MEM_RDATA <= (win_rd && win_is_timer(win_off)) ? ACPI_TIMER_COUNT : 32'h00000000;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IO_HIT   <= 1'b0;
      IO_RDATA <= 32'h00000000;
    end else begin
      IO_HIT   <= IO_RD && IO_ADDR == `CSS_IO_ACPI_TMR;
      IO_RDATA <= (IO_RD && IO_ADDR == `CSS_IO_ACPI_TMR) ? ACPI_TIMER_COUNT : 32'h00000000;
    end
  end

  // SYSTEM_MGMT_EVENT speedup: halt flag until the handler reads offset 08h; set beats clear
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      smi_halt <= 1'b0;
    end else if (smi_evt && suspend_cfg[`CSS_CFG_MOD_EN] &&
                 suspend_cfg[`CSS_CFG_SMI_SPEEDUP]) begin
      smi_halt <= 1'b1;
    end else if (!suspend_cfg[`CSS_CFG_MOD_EN]) begin
      smi_halt <= 1'b0;
    end else if (win_rd && win_off == `CSS_WIN_SPEEDUP_DIS) begin
      smi_halt <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SPEEDUP_LOAD <= 1'b0;
    end else begin
      SPEEDUP_LOAD <= smi_evt && suspend_cfg[`CSS_CFG_MOD_EN] &&
                      !suspend_cfg[`CSS_CFG_SMI_SPEEDUP];
    end
  end

  assign mod_inhibit = smi_halt || SPEEDUP_ACTIVE || state != css_pkg::CSS_IDLE;

  css_modulator #(
    .INTERVAL_CYCLES (INTERVAL_CYCLES)
  ) u_mod (
    .clk        (REF_CLK),
    .rst_n      (RESET_N),
    .enable     (suspend_cfg[`CSS_CFG_MOD_EN]),
    .inhibit    (mod_inhibit),
    .off_count  (MOD_OFF_COUNT),
    .on_count   (MOD_ON_COUNT),
    .assert_req (mod_assert)
  );

  // break events; the processor stays halted until one of these
  assign break_cpu   = cpu_interrupt_request_s || smi_s;
  assign break_stop  = smi_s || irq_s;
  assign full_suspend = clk_stop_ctl[`CSS_CSC_FULL_SUSPEND];
  assign resync_done = ms_left == 4'h0 && ms_cnt == '0;

  always_comb begin
    next_state = state;
    case (state)
      css_pkg::CSS_IDLE: begin
        if (cmd_wr) begin
          next_state = css_pkg::CSS_REQ;
        end
      end
      css_pkg::CSS_REQ: begin
        if (break_cpu) begin
          next_state = css_pkg::CSS_IDLE;
        end else if (ack_s) begin
          next_state = css_pkg::CSS_HALTED;
        end
      end
      css_pkg::CSS_HALTED: begin
        if (break_cpu) begin
          next_state = css_pkg::CSS_IDLE;
        end else if (full_suspend && ack_s) begin
          next_state = css_pkg::CSS_CLK_STOP;
        end
      end
      css_pkg::CSS_CLK_STOP: begin
        if (break_stop) begin
          next_state = css_pkg::CSS_RESYNC;
        end
      end
      css_pkg::CSS_RESYNC: begin
        if (resync_done) begin
          next_state = css_pkg::CSS_IDLE;
        end
      end
      default: begin
        next_state = css_pkg::CSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= css_pkg::CSS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // re-sync delay: field value in whole milliseconds
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ms_left <= 4'h0;
      ms_cnt  <= '0;
    end else if (state == css_pkg::CSS_CLK_STOP) begin
      ms_left <= clk_stop_ctl[`CSS_CSC_DELAY_MSB:`CSS_CSC_DELAY_LSB];
      ms_cnt  <= '0;
    end else if (state == css_pkg::CSS_RESYNC && !resync_done) begin
      if (ms_cnt == '0) begin
        ms_cnt  <= MW'(MS_CYCLES - 1);
        ms_left <= ms_left - 4'h1;
      end else begin
        ms_cnt <= ms_cnt - MW'(1);
      end
    end
  end

  // processor-facing outputs
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CPU_SUSPEND_REQUEST_N   <= 1'b1;
      SYSTEM_MGMT_INTERRUPT_N <= 1'b1;
    end else begin
      CPU_SUSPEND_REQUEST_N   <= !(state != css_pkg::CSS_IDLE || mod_assert);
      SYSTEM_MGMT_INTERRUPT_N <= !(state == css_pkg::CSS_RESYNC);
    end
  end

  // halted idle: ack drops while bus masters run, so gating follows it
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      INTERNAL_CLK_GATE <= 1'b0;
      ISA_CLK_GATE      <= 1'b0;
      CPU_POWER_OFF_OK  <= 1'b0;
    end else begin
      INTERNAL_CLK_GATE <= ack_s && !suspend_cfg[`CSS_CFG_PWR_SAVE_DIS];
      ISA_CLK_GATE      <= ack_s && !suspend_cfg[`CSS_CFG_PWR_SAVE_DIS] &&
                           suspend_cfg[`CSS_CFG_ISA_GATE];
      CPU_POWER_OFF_OK  <= suspend_cfg[`CSS_CFG_3V_MODE] &&
                           (state == css_pkg::CSS_HALTED ||
                            state == css_pkg::CSS_CLK_STOP);
    end
  end

  // clock stop pin stays an input until its strap level has settled
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_cnt    <= 2'h0;
      strap_done   <= 1'b0;
      csi_inactive <= 1'b0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == `CSS_STRAP_SETTLE) begin
        strap_done   <= 1'b1;
        csi_inactive <= csi_s;
      end
    end
  end

  assign csi_active_now = state == css_pkg::CSS_CLK_STOP;

  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CLOCK_STOP_INDICATOR_OUT <= 1'b0;
      CLOCK_STOP_INDICATOR_OE  <= 1'b0;
    end else begin
      CLOCK_STOP_INDICATOR_OUT <= strap_done && (csi_active_now ^ csi_inactive);
      CLOCK_STOP_INDICATOR_OE  <= strap_done;
    end
  end

endmodule : css_sequencer

`default_nettype wire

// ---- css_sequencer_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module css_sequencer_chk #(
  parameter int MS_CYCLES = 100000
) (
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        CFG_RD,
  input wire logic        CFG_FUNC,
  input wire logic [7:0]  CFG_INDEX,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        MEM_RD,
  input wire logic [31:0] MEM_ADDR,
  input wire logic        MEM_HIT,
  input wire logic [31:0] MEM_RDATA,
  input wire logic        IO_RD,
  input wire logic [15:0] IO_ADDR,
  input wire logic        IO_HIT,
  input wire logic [31:0] IO_RDATA,
  input wire logic [31:0] ACPI_TIMER_COUNT,
  input wire logic        CPU_SUSPEND_REQUEST_N,
  input wire logic        CPU_SUSPEND_ACK_N,
  input wire logic        SYSTEM_MGMT_INTERRUPT_N,
  input wire logic        CLK_32K,
  input wire logic        DEVICE_TIMER_TICK,
  input wire logic        CLOCK_STOP_INDICATOR_IN,
  input wire logic        CLOCK_STOP_INDICATOR_OUT,
  input wire logic        CLOCK_STOP_INDICATOR_OE
);
  localparam int LIM = 15 * MS_CYCLES + 4;
  logic        strap;
  logic [31:0] low_cnt;
  logic        act;
  assign act = CLOCK_STOP_INDICATOR_OE && (CLOCK_STOP_INDICATOR_OUT != strap);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // pin level seen while undriven is the idle level
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap <= 1'b0;
    end else if (!CLOCK_STOP_INDICATOR_OE) begin
      strap <= CLOCK_STOP_INDICATOR_IN;
    end
  end
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_cnt <= 32'h0;
    end else if (SYSTEM_MGMT_INTERRUPT_N) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= low_cnt + 32'h1;
    end
  end
  chk_smi_in_req: assert property (!SYSTEM_MGMT_INTERRUPT_N |-> !CPU_SUSPEND_REQUEST_N)
    else $error("smi low without suspend request");
  chk_stop_needs_req: assert property (act |-> !CPU_SUSPEND_REQUEST_N)
    else $error("clock stop without suspend request");
  chk_stop_after_ack: assert property ($rose(act) |-> !$past(CPU_SUSPEND_ACK_N, 3))
    else $error("clock stop before acknowledge");
  chk_strap_idle: assert property ($rose(CLOCK_STOP_INDICATOR_OE)
      |-> CLOCK_STOP_INDICATOR_OUT == strap)
    else $error("indicator not idle at strap level");
  chk_wake_smi: assert property ($fell(act) |-> !SYSTEM_MGMT_INTERRUPT_N)
    else $error("wake without smi output");
  chk_resync_bound: assert property ($rose(SYSTEM_MGMT_INTERRUPT_N) |-> low_cnt <= LIM)
    else $error("resync delay too long");
  chk_base_low: assert property (CFG_RD && CFG_FUNC && CFG_INDEX == 8'h10
      |=> CFG_RDATA[7:0] == 8'h00)
    else $error("base low byte not zero");
  chk_win_timer: assert property (MEM_RD && MEM_ADDR[7:4] == 4'hf
      |=> !MEM_HIT || MEM_RDATA == $past(ACPI_TIMER_COUNT))
    else $error("window top not timer");
  chk_port_timer: assert property (IO_RD |=> IO_HIT == ($past(IO_ADDR) == 16'h121c)
      && (!IO_HIT || IO_RDATA == $past(ACPI_TIMER_COUNT)))
    else $error("timer port read wrong");
  chk_tick_32k: assert property ($rose(CLK_32K) |-> ##[1:5] DEVICE_TIMER_TICK)
    else $error("no timer tick");
endmodule : css_sequencer_chk
bind css_sequencer css_sequencer_chk #(.MS_CYCLES(MS_CYCLES)) i_css_sequencer_chk (.*);
`default_nettype wire

// ---- css_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module css_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       req_n,
  input  wire logic       brk,
  input  wire logic       bus_req,
  input  wire logic [7:0] dly,
  output logic            ack_n
);
  logic [7:0] cnt;
  logic       halted;
  // after a break no new halt until the request is dropped, unless dly is 8'hff
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halted <= 1'b0;
      cnt <= 8'h00;
    end else if (req_n) begin
      halted <= 1'b0;
      cnt <= 8'h00;
    end else if (brk) begin
      halted <= 1'b0;
      cnt <= 8'hff;
    end else if (cnt < dly) begin
      cnt <= cnt + 8'h01;
    end else if (cnt == dly) begin
      halted <= 1'b1;
    end
  end
  assign ack_n = !(halted && !bus_req);
endmodule : css_cpu_model
`default_nettype wire

// ---- css_sequencer_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module css_sequencer_bench;
  localparam int MS = 10;
  localparam int IV = 8;
  logic        REF_CLK = 1'b0, RESET_N = 1'b0, CFG_WR = 1'b0, CFG_RD = 1'b0, CFG_FUNC = 1'b0;
  logic        MEM_RD = 1'b0, IO_RD = 1'b0, SPEEDUP_ACTIVE = 1'b0, CPU_INTERRUPT_REQUEST = 1'b0;
  logic        IRQ_UNMASKED = 1'b0, EXT_SMI_N = 1'b1, CLK_32K = 1'b0, bus_req = 1'b0, strap = 1'b1;
  logic [7:0]  CFG_INDEX = 8'h00, MOD_OFF_COUNT = 8'h00, MOD_ON_COUNT = 8'h00, dly = 8'h00;
  logic [15:0] IO_ADDR = 16'h0;
  logic [31:0] CFG_WDATA = 32'h0, MEM_ADDR = 32'h0, ACPI_TIMER_COUNT = 32'h0, rnd = 32'h17b9a;
  logic [31:0] CFG_RDATA, MEM_RDATA, IO_RDATA, b, d;
  logic        MEM_HIT, IO_HIT, SPEEDUP_LOAD, CPU_SUSPEND_REQUEST_N, CPU_SUSPEND_ACK_N;
  logic        SYSTEM_MGMT_INTERRUPT_N, DEVICE_TIMER_TICK, CLOCK_STOP_INDICATOR_OUT;
  logic        CLOCK_STOP_INDICATOR_OE, INTERNAL_CLK_GATE, ISA_CLK_GATE, CPU_POWER_OFF_OK;
  logic [7:0]  regs [3] = '{8'h96, 8'hbc, 8'h10};
  logic [7:0]  cf [3] = '{8'h0c, 8'h10, 8'h04};
  logic [3:0]  nv [3] = '{4'h0, 4'h3, 4'hf};
  // pull resistor holds the strap level whenever the pin is not driven
  wire logic   CLOCK_STOP_INDICATOR_IN = CLOCK_STOP_INDICATOR_OE ? CLOCK_STOP_INDICATOR_OUT
                                         : strap;
  wire logic   stop_act = CLOCK_STOP_INDICATOR_OE && (CLOCK_STOP_INDICATOR_OUT != strap);
  int          n_errors = 0, comparisons = 0, cyc = 0, k, loads;

  css_sequencer #(.MS_CYCLES(MS), .INTERVAL_CYCLES(IV)) i_css_sequencer (.*);
  css_cpu_model i_css_cpu_model (.clk(REF_CLK), .rst_n(RESET_N), .req_n(CPU_SUSPEND_REQUEST_N),
    .brk(CPU_INTERRUPT_REQUEST || IRQ_UNMASKED || !EXT_SMI_N), .bus_req(bus_req), .dly(dly),
    .ack_n(CPU_SUSPEND_ACK_N));

  always #5 REF_CLK = ~REF_CLK;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic logic [31:0] cfg_mask(input logic [7:0] idx, input logic [31:0] v);
    return v & ((idx == 8'h96) ? 32'h1f : (idx == 8'hbc) ? 32'hf1 : 32'hffffff00);
  endfunction : cfg_mask

  task automatic end_of_test;
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cfg(input logic wr, input logic f, input logic [7:0] idx, input logic [31:0] v);
    @(negedge REF_CLK);
    CFG_WR = wr;
    CFG_RD = !wr;
    CFG_FUNC = f;
    CFG_INDEX = idx;
    CFG_WDATA = v;
    @(negedge REF_CLK);
    CFG_WR = 1'b0;
    CFG_RD = 1'b0;
  endtask : cfg

  task automatic rd(input logic io, input logic [31:0] a, input logic hit, input logic tmr);
    @(negedge REF_CLK);
    rnd = lfsr(rnd);
    ACPI_TIMER_COUNT = rnd;
    MEM_RD = !io;
    IO_RD = io;
    MEM_ADDR = a;
    IO_ADDR = a[15:0];
    @(negedge REF_CLK);
    MEM_RD = 1'b0;
    IO_RD = 1'b0;
    check("hit", 32'(io ? IO_HIT : MEM_HIT), 32'(hit));
    check("rdata", io ? IO_RDATA : MEM_RDATA, (hit && tmr) ? rnd : 32'h0);
  endtask : rd

  task automatic span(input logic lvl);
    k = 0;
    while (CPU_SUSPEND_REQUEST_N === lvl && k < 300) begin
      @(negedge REF_CLK);
      k++;
    end
  endtask : span

  task automatic system_mgmt_event;
    loads = 0;
    @(negedge REF_CLK);
    EXT_SMI_N = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge REF_CLK);
      EXT_SMI_N = (i > 2);
      loads += int'(SPEEDUP_LOAD === 1'b1);
    end
  endtask : system_mgmt_event

  always @(negedge REF_CLK) begin
    cyc++;
    CLK_32K = cyc[6];
    if (cyc == 30000) begin
      n_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(negedge REF_CLK);
    RESET_N = 1'b1;
    repeat (8) @(negedge REF_CLK);
    for (int i = 0; i < 5; i++) begin
      foreach (regs[j]) begin
        rnd = lfsr(rnd);
        d = (i == 1) ? 32'hffffffff : rnd;
        if (i > 0) cfg(1'b1, j == 2, regs[j], d);
        if (j == 2) b = cfg_mask(regs[j], d);
        cfg(1'b0, j == 2, regs[j], 32'h0);
        check("reg", CFG_RDATA, (i > 0) ? cfg_mask(regs[j], d) : 32'h0);
      end
    end
    cfg(1'b0, 1'b0, 8'h55, 32'h0);
    check("unmapped", CFG_RDATA, 32'h0);
    rd(1'b0, b | 32'h1c, 1'b1, 1'b1);
    rd(1'b0, b | {24'h0, 4'hf, rnd[3:0]}, 1'b1, 1'b1);
    rd(1'b0, b | 32'h08, 1'b1, 1'b0);
    rd(1'b0, b ^ 32'h100, 1'b0, 1'b0);
    rd(1'b1, 32'h121c, 1'b1, 1'b1);
    rd(1'b1, 32'h121d, 1'b0, 1'b0);
    foreach (cf[i]) begin
      dly = {5'h0, rnd[2:0]};
      rnd = lfsr(rnd);
      cfg(1'b1, 1'b0, 8'h96, {24'h0, cf[i]});
      cfg(1'b1, 1'b0, 8'hbc, 32'h0);
      cfg(1'b1, 1'b0, 8'hae, rnd);
      for (k = 0; k < 40 && CPU_SUSPEND_ACK_N !== 1'b0; k++) @(negedge REF_CLK);
      repeat (4) @(negedge REF_CLK);
      check("gate", 32'(INTERNAL_CLK_GATE), 32'(!cf[i][4]));
      check("isa", 32'(ISA_CLK_GATE), 32'(!cf[i][4] && cf[i][3]));
      check("poweroff", 32'(CPU_POWER_OFF_OK), 32'(cf[i][2]));
      bus_req = 1'b1;
      repeat (5) @(negedge REF_CLK);
      check("busgate", 32'(INTERNAL_CLK_GATE), 32'h0);
      bus_req = 1'b0;
      repeat (5) @(negedge REF_CLK);
      check("nostop", 32'(stop_act), 32'h0);
      CPU_INTERRUPT_REQUEST = 1'b1;
      for (k = 0; k < 8 && !CPU_SUSPEND_REQUEST_N; k++) @(negedge REF_CLK);
      check("break", 32'(CPU_SUSPEND_REQUEST_N), 32'h1);
      CPU_INTERRUPT_REQUEST = 1'b0;
    end
    cfg(1'b1, 1'b0, 8'h96, 32'h0);
    foreach (nv[i]) begin
      cfg(1'b1, 1'b0, 8'hbc, {24'h0, nv[i], 4'h1});
      cfg(1'b1, 1'b0, 8'hae, 32'h0);
      for (k = 0; k < 40 && !stop_act; k++) @(negedge REF_CLK);
      check("stop", 32'(stop_act), 32'h1);
      check("req", 32'(CPU_SUSPEND_REQUEST_N), 32'h0);
      EXT_SMI_N = nv[i][0];
      IRQ_UNMASKED = nv[i][0];
      for (k = 0; k < 10 && stop_act; k++) @(negedge REF_CLK);
      check("wake", 32'(stop_act), 32'h0);
      check("smi", 32'(SYSTEM_MGMT_INTERRUPT_N), 32'h0);
      EXT_SMI_N = 1'b1;
      IRQ_UNMASKED = 1'b0;
      span(1'b0);
      check("resync", 32'(k >= nv[i] * MS && k <= nv[i] * MS + 4), 32'h1);
    end
    MOD_OFF_COUNT = 8'h02;
    MOD_ON_COUNT = 8'h03;
    cfg(1'b1, 1'b0, 8'h96, 32'h1);
    span(1'b1);
    span(1'b0);
    check("offlen", 32'(k >= 2 * IV - 1 && k <= 2 * IV + 1), 32'h1);
    span(1'b1);
    check("onlen", 32'(k >= 3 * IV - 1 && k <= 3 * IV + 1), 32'h1);
    SPEEDUP_ACTIVE = 1'b1;
    system_mgmt_event();
    check("load", loads, 32'h1);
    cfg(1'b1, 1'b0, 8'h96, 32'h2);
    system_mgmt_event();
    check("noload", loads, 32'h0);
    SPEEDUP_ACTIVE = 1'b0;
    cfg(1'b1, 1'b0, 8'h96, 32'h3);
    system_mgmt_event();
    span(1'b1);
    check("halted", k, 32'd300);
    rd(1'b0, b | 32'h08, 1'b1, 1'b0);
    span(1'b1);
    check("resumed", 32'(k < 300), 32'h1);
    MOD_ON_COUNT = 8'h00;
    span(1'b0);
    check("onzero", k, 32'd300);
    MOD_OFF_COUNT = 8'h00;
    repeat (3) @(negedge REF_CLK);
    span(1'b1);
    check("offzero", k, 32'd300);
    end_of_test();
  end
endmodule : css_sequencer_bench
`default_nettype wire
